// >>> core/timer_ctrl_pkg.sv
// Package for the 16-bit timer with its 8-bit control register.
// Assumes a plain register port: address, write data, strobes, read data.
package timer_ctrl_pkg;

    // Register indices on the plain port
    localparam logic [2:0] ADDR_CONTROL    = 3'h0;
    localparam logic [2:0] ADDR_COUNT_LOW  = 3'h1;
    localparam logic [2:0] ADDR_COUNT_HIGH = 3'h2;
    localparam logic [2:0] ADDR_IRQ_STATUS = 3'h3;
    localparam logic [2:0] ADDR_IRQ_CLEAR  = 3'h4;
    localparam logic [2:0] ADDR_IRQ_ENABLE = 3'h5;

    // Control field positions
    localparam int CTL_RUN_BIT    = 0;
    localparam int CTL_WIDE_BIT   = 1;
    localparam int CTL_BYPASS_BIT = 2;
    localparam int CTL_OSC_BIT    = 3;
    localparam int CTL_PRE_LSB    = 4;
    localparam int CTL_CS_LSB     = 6;

    localparam logic [7:0]  CONTROL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET   = 16'h0000;
    localparam logic [0:0]  IRQ_RESET     = 1'h0;

    // Clock source codes
    localparam logic [1:0] CS_INSTR  = 2'h0;
    localparam logic [1:0] CS_SYSTEM = 2'h1;
    localparam logic [1:0] CS_EXT    = 2'h2;

    // Instruction clock is the system clock divided by four
    localparam int INSTR_DIV = 4;

    // Secondary oscillator mode configuration codes
    localparam logic [1:0] OSC_LOW_POWER  = 2'h1;
    localparam logic [1:0] OSC_DIGITAL    = 2'h2;
    localparam logic [1:0] OSC_HIGH_POWER = 2'h3;

    typedef struct packed {
        logic [1:0] count_clock_select;
        logic [1:0] prescale_select;
        logic       secondary_osc_enable;
        logic       ext_clock_sync_bypass;
        logic       wide_access_enable;
        logic       count_run;
    } timer_control_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    typedef struct packed {
        logic ext_count_clock_pin;
        logic secondary_crystal_in;
    } ext_in_t;

    typedef struct packed {
        logic osc_enable;
        logic osc_low_power;
        logic osc_high_power;
        logic osc_digital;
    } osc_ctl_t;

endpackage

// >>> core/edge_sync.sv
// Rising-edge detector for an external count clock, with optional sync.
// Input is an asynchronous level; bypass skips the two-flop stage.
`timescale 1ns/1ps
module edge_sync
(
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // Signal
    input  wire logic raw_in,
    input  wire logic bypass,
    output logic      rise
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;
    logic sel;

    // Bypass trades metastability safety for two fewer cycles of latency
    assign sel  = bypass ? raw_in : sync_ff;
    assign rise = sel & ~prev_ff;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= raw_in;
            sync_ff <= meta_ff;
            prev_ff <= sel;
        end
    end
endmodule

// >>> core/tick_prescaler.sv
// Prescaler: passes one tick of every 1, 2, 4 or 8 input ticks.
// Cleared while the timer is stopped so a restart begins a fresh period.
`timescale 1ns/1ps
module tick_prescaler
#(
    parameter int WIDTH = 3
)
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // Control
    input  wire logic       clear,
    input  wire logic [1:0] prescale_select,
    // Ticks
    input  wire logic       tick_in,
    output logic            tick_out
);
    logic [WIDTH-1:0] cnt_ff;
    logic [WIDTH-1:0] nxt_cnt;
    logic [WIDTH-1:0] limit;

    assign limit    = WIDTH'((1 << prescale_select) - 1);
    assign tick_out = tick_in & (cnt_ff >= limit);
    assign nxt_cnt  = clear    ? '0 :
                      tick_out ? '0 :
                      tick_in  ? cnt_ff + WIDTH'(1) : cnt_ff;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            cnt_ff <= '0;
        else
            cnt_ff <= nxt_cnt;
    end
endmodule

// >>> core/sixteen_bit_timer_control.sv
// 16-bit timer/counter with control register, byte access and interrupt.
// Assumes register strobes synchronous to sys_clk, one cycle each.
// Function
// RULE1 - Clock select: instruction, system or external
// RULE2 - External: pin edges or secondary oscillator
// RULE3 - Prescale one, two, four or eight
// RULE4 - External clock synchronised unless bypass set
// RULE5 - Internal clock ignores the bypass bit
// RULE6 - Bypass unusable when device clocked by timer
// RULE7 - Wide bit picks 16-bit or 8-bit access
// RULE8 - Run bit zero stops and holds count
// RULE9 - Oscillator enable bit drives secondary oscillator
// RULE10 - Avoid system clock when timing capture/compare
// RULE11 - Count held as low and high bytes
// RULE12 - Control register resets to zero
// RULE13 - Oscillator mode from two-bit configuration
// RULE14 - Count wraps and sets overflow flag
// RULE15 - Wide mode buffers high byte both ways
`timescale 1ns/1ps
module sixteen_bit_timer_control
#(
    parameter int COUNT_WIDTH = 16
)
(
    // Clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       rst,
    // Register port
    input  wire timer_ctrl_pkg::reg_req_t   reg_req,
    output logic [7:0]                      reg_rdata,
    // External count sources
    input  wire timer_ctrl_pkg::ext_in_t    ext_in,
    input  wire logic [1:0]                 secondary_osc_mode_config,
    // Oscillator control
    output timer_ctrl_pkg::osc_ctl_t        osc_ctl,
    output logic                            secondary_crystal_out,
    // Interrupt
    output logic                            irq
);
    import timer_ctrl_pkg::*;

    timer_control_t         ctl_ff;
    logic [COUNT_WIDTH-1:0] count_ff;
    logic [7:0]             high_buf_ff;
    logic [7:0]             rdata_ff;
    logic [1:0]             div_ff;
    logic                   ovf_status_ff;
    logic                   ovf_enable_ff;
    logic                   osc_out_ff;

    // Register decode
    function automatic logic hit(input logic [2:0] a, input logic [2:0] r);
        hit = (a == r);
    endfunction

    wire wr_ctl    = reg_req.wr & hit(reg_req.addr, ADDR_CONTROL);
    wire wr_low    = reg_req.wr & hit(reg_req.addr, ADDR_COUNT_LOW);
    wire wr_high   = reg_req.wr & hit(reg_req.addr, ADDR_COUNT_HIGH);
    wire wr_clear  = reg_req.wr & hit(reg_req.addr, ADDR_IRQ_CLEAR);
    wire wr_enable = reg_req.wr & hit(reg_req.addr, ADDR_IRQ_ENABLE);
    wire rd_low    = reg_req.rd & hit(reg_req.addr, ADDR_COUNT_LOW);

    // Instruction clock tick: one of every INSTR_DIV system clocks
    wire instr_tick = (div_ff == 2'(INSTR_DIV - 1));

    // External source selection
    wire ext_sel   = ctl_ff.count_clock_select == CS_EXT;
    wire osc_on    = ctl_ff.secondary_osc_enable;                      // RULE9
    wire ext_raw   = osc_on ? ext_in.secondary_crystal_in
                            : ext_in.ext_count_clock_pin;              // RULE2
    // Bypass only matters with the external source selected
    wire bypass_eff = ext_sel & ctl_ff.ext_clock_sync_bypass;          // RULE5
    wire ext_rise;

    edge_sync u_edge_sync
    (
        .sys_clk (sys_clk),
        .rst     (rst),
        .raw_in  (ext_raw),
        .bypass  (bypass_eff),                                         // RULE4
        .rise    (ext_rise)
    );

    // Source tick; code 11 is unassigned and gives no ticks
    logic src_tick;
    always_comb
    begin
        case (ctl_ff.count_clock_select)
            CS_INSTR:  src_tick = instr_tick;                          // RULE1
            CS_SYSTEM: src_tick = 1'b1;                                // RULE1
            CS_EXT:    src_tick = ext_rise;                            // RULE1
            default:   src_tick = 1'b0;
        endcase
    end

    wire count_tick;

    tick_prescaler #(.WIDTH(3)) u_prescaler
    (
        .sys_clk         (sys_clk),
        .rst             (rst),
        .clear           (~ctl_ff.count_run),
        .prescale_select (ctl_ff.prescale_select),                     // RULE3
        .tick_in         (src_tick & ctl_ff.count_run),                // RULE8
        .tick_out        (count_tick)
    );

    // Count update; a software write wins over a tick in the same cycle
    wire                   wrap     = count_tick & (&count_ff);       // RULE14
    wire [7:0]             cur_high = count_ff[COUNT_WIDTH-1:8];
    wire [7:0]             low_new  = reg_req.wdata;
    wire [7:0]             high_new = ctl_ff.wide_access_enable
                                      ? high_buf_ff : reg_req.wdata;
    logic [COUNT_WIDTH-1:0] nxt_count;
    always_comb
    begin
        nxt_count = count_ff;
        if (count_tick)
            nxt_count = count_ff + COUNT_WIDTH'(1);                    // RULE14
        if (wr_low)
            nxt_count = ctl_ff.wide_access_enable
                        ? {high_new, low_new}                          // RULE15
                        : {cur_high, low_new};                         // RULE7
        else if (wr_high && !ctl_ff.wide_access_enable)
            nxt_count = {reg_req.wdata, count_ff[7:0]};                // RULE7
    end

    // High-byte buffer: in wide mode, filled by low-byte read or high-byte write
    logic [7:0] nxt_high_buf;
    always_comb
    begin
        nxt_high_buf = high_buf_ff;
        if (ctl_ff.wide_access_enable && rd_low)
            nxt_high_buf = cur_high;                                   // RULE15
        else if (ctl_ff.wide_access_enable && wr_high)
            nxt_high_buf = reg_req.wdata;                              // RULE15
    end

    // Read multiplexer
    logic [7:0] nxt_rdata;
    always_comb
    begin
        case (reg_req.addr)
            ADDR_CONTROL:    nxt_rdata = ctl_ff;
            ADDR_COUNT_LOW:  nxt_rdata = count_ff[7:0];                // RULE11
            ADDR_COUNT_HIGH: nxt_rdata = ctl_ff.wide_access_enable
                                         ? high_buf_ff : cur_high;     // RULE11
            ADDR_IRQ_STATUS: nxt_rdata = {7'h00, ovf_status_ff};
            ADDR_IRQ_ENABLE: nxt_rdata = {7'h00, ovf_enable_ff};
            default:         nxt_rdata = 8'h00;
        endcase
        if (!reg_req.rd)
            nxt_rdata = 8'h00;
    end

    // Oscillator mode decode; digital mode needs no crystal drive
    wire osc_mode_crystal =
        (secondary_osc_mode_config == OSC_LOW_POWER) |
        (secondary_osc_mode_config == OSC_HIGH_POWER);

    // Overflow flag: a wrap in the clearing cycle still sets it
    wire nxt_status = wrap | (ovf_status_ff &
                      ~(wr_clear & reg_req.wdata[0]));                 // RULE14

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ctl_ff        <= CONTROL_RESET;                            // RULE12
            count_ff      <= COUNT_RESET;
            high_buf_ff   <= 8'h00;
            rdata_ff      <= 8'h00;
            div_ff        <= 2'h0;
            ovf_status_ff <= IRQ_RESET[0];
            ovf_enable_ff <= IRQ_RESET[0];
            osc_out_ff    <= 1'b0;
        end
        else
        begin
            if (wr_ctl)
                ctl_ff <= timer_control_t'(reg_req.wdata);
            count_ff      <= nxt_count;
            high_buf_ff   <= nxt_high_buf;
            rdata_ff      <= nxt_rdata;
            div_ff        <= div_ff + 2'h1;
            ovf_status_ff <= nxt_status;
            if (wr_enable)
                ovf_enable_ff <= reg_req.wdata[0];
            // Crystal drive is the inverted input while the amplifier runs
            osc_out_ff    <= osc_on & osc_mode_crystal &
                             ~ext_in.secondary_crystal_in;
        end
    end

    always_comb
    begin
        osc_ctl.osc_enable     = osc_on;                               // RULE9
        osc_ctl.osc_low_power  = osc_on &
            (secondary_osc_mode_config == OSC_LOW_POWER);              // RULE13
        osc_ctl.osc_high_power = osc_on &
            (secondary_osc_mode_config == OSC_HIGH_POWER);             // RULE13
        osc_ctl.osc_digital    = osc_on &
            (secondary_osc_mode_config == OSC_DIGITAL);                // RULE13
    end

    assign secondary_crystal_out = osc_out_ff;
    assign reg_rdata             = rdata_ff;
    assign irq                   = ovf_status_ff & ovf_enable_ff;
endmodule

// >>> tb/timer_ctrl_assertions.sv
// Checker for the timer block, bound to its top-level ports.
// Assumes the timer package is compiled first.
`timescale 1ns/1ps
module timer_ctrl_assertions
#(
    parameter int COUNT_WIDTH = 16
)
(
    // Clock and reset
    input wire logic                     sys_clk,
    input wire logic                     rst,
    // Watched ports
    input wire timer_ctrl_pkg::reg_req_t reg_req,
    input wire logic [7:0]               reg_rdata,
    input wire timer_ctrl_pkg::ext_in_t  ext_in,
    input wire logic [1:0]               secondary_osc_mode_config,
    input wire timer_ctrl_pkg::osc_ctl_t osc_ctl,
    input wire logic                     secondary_crystal_out,
    input wire logic                     irq
);
    import timer_ctrl_pkg::*;
    logic [7:0] ctl_ff;
    logic [7:0] nxt_ctl;
    wire        ctl_wr = reg_req.wr && reg_req.addr == ADDR_CONTROL;
    wire        rd_low = reg_req.rd && reg_req.addr == ADDR_COUNT_LOW;
    // Shadow of the control register, seen only through writes
    assign nxt_ctl = ctl_wr ? reg_req.wdata : ctl_ff;
    always_ff @(posedge sys_clk)
    begin
        ctl_ff <= rst ? CONTROL_RESET : nxt_ctl;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_rdata_idle: assert property (!$past(reg_req.rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside its slot");
    a_ctl_readback: assert property (reg_req.rd && reg_req.addr == ADDR_CONTROL
        |=> reg_rdata == $past(ctl_ff)) else $error("control readback wrong");
    a_clear_zero: assert property (reg_req.rd && reg_req.addr == ADDR_IRQ_CLEAR
        |=> reg_rdata == 8'h00) else $error("clear register not read as zero");
    a_osc_follows: assert property (osc_ctl.osc_enable == ctl_ff[CTL_OSC_BIT])
        else $error("oscillator enable differs from control bit");
    a_osc_mode: assert property (osc_ctl.osc_enable |->
        osc_ctl.osc_low_power == (secondary_osc_mode_config == OSC_LOW_POWER)
        && osc_ctl.osc_high_power == (secondary_osc_mode_config == OSC_HIGH_POWER)
        && osc_ctl.osc_digital == (secondary_osc_mode_config == OSC_DIGITAL))
        else $error("oscillator mode outputs wrong");
    a_irq_masked: assert property (reg_req.wr && !reg_req.wdata[0]
        && reg_req.addr == ADDR_IRQ_ENABLE |=> !irq) else $error("masked irq high");
    a_hold_stopped: assert property ((rd_low && !ctl_ff[0]) ##1 !reg_req.wr
        ##1 (rd_low && !ctl_ff[0]) |=> reg_rdata == $past(reg_rdata, 2))
        else $error("count moved while stopped");
    a_crystal_drive: assert property (osc_ctl.osc_enable
        && (osc_ctl.osc_low_power || osc_ctl.osc_high_power) |=>
        secondary_crystal_out == !$past(ext_in.secondary_crystal_in))
        else $error("crystal output not inverted input");
endmodule
bind sixteen_bit_timer_control timer_ctrl_assertions
    #(.COUNT_WIDTH(COUNT_WIDTH)) chk (.sys_clk, .rst, .reg_req, .reg_rdata,
    .ext_in, .secondary_osc_mode_config, .osc_ctl, .secondary_crystal_out, .irq);

// >>> tb/ext_clock_source.sv
// Far-side model: external count clock pin and secondary crystal.
// Assumes the bench calls its tasks; both lines rest low between bursts.
`timescale 1ns/1ps
module ext_clock_source
(
    // Oscillator control from the block
    input  wire logic osc_en,
    // Clock lines
    output logic      pin,
    output logic      xtal
);
    // Runs from its own delays, never from the block's clock
    initial
    begin
        pin = 1'b0;
        xtal = 1'b0;
    end
    task automatic pin_edges(input int n, input int half);
        // Step off the clock edge so no pin change lands on one
        #1;
        repeat (n)
        begin
            #(half) pin = 1'b1;
            #(half) pin = 1'b0;
        end
    endtask
    // A crystal only swings while the block powers it
    task automatic xtal_cycles(input int n, input int half);
        #1;
        repeat (n)
        begin
            #(half) xtal = osc_en;
            #(half) xtal = 1'b0;
        end
    endtask
endmodule

// >>> tb/sixteen_bit_timer_control_tb.sv
// Self-checking bench for the 16-bit timer block.
// Assumes the package, design, checker and clock source are compiled first.
`timescale 1ns/1ps
module sixteen_bit_timer_control_tb;
    import timer_ctrl_pkg::*;
    logic       sys_clk = 1'b0;
    logic       rst = 1'b1;
    reg_req_t   reg_req = '0;
    logic [1:0] osc_cfg = OSC_LOW_POWER;
    logic [7:0] reg_rdata;
    osc_ctl_t   osc_ctl;
    logic       xtal_out, irq, pin, xtal;
    logic       pend = 1'b0;
    logic [7:0] exp_q[$];
    int         tol_q[$];
    int         fails = 0;
    int         check_count = 0;
    int         v, k;
    always #20 sys_clk = ~sys_clk;
    ext_clock_source far (.osc_en(osc_ctl.osc_enable), .pin(pin), .xtal(xtal));
    sixteen_bit_timer_control dut (.sys_clk, .rst, .reg_req, .reg_rdata,
        .ext_in({pin, xtal}), .secondary_osc_mode_config(osc_cfg), .osc_ctl,
        .secondary_crystal_out(xtal_out), .irq);
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmp_byte(input logic [7:0] e, input int t, input logic [7:0] s);
        int d;
        d = int'(s) - int'(e);
        check_count++;
        if (t == 0 ? s !== e : ($isunknown(s) || d > t || d < -t))
        begin
            fails++;
            $display("Error reg_rdata expected %h seen %h", e, s);
        end
    endtask
    task automatic cmp_bit(input logic e, input logic s);
        check_count++;
        if (s !== e)
        begin
            fails++;
            $display("Error irq expected %b seen %b", e, s);
        end
    endtask
    // Read data stand only in the cycle after the strobe
    always @(posedge sys_clk)
    begin
        if (pend)
            cmp_byte(exp_q.pop_front(), tol_q.pop_front(), reg_rdata);
        pend <= reg_req.rd && !rst;
    end
    task automatic bus(input logic [2:0] a, input logic [7:0] d, input logic w,
                       input logic r);
        @(posedge sys_clk);
        reg_req <= '{a, d, w, r};
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        bus(a, d, 1'b1, 1'b0);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e, input int t);
        exp_q.push_back(e);
        tol_q.push_back(t);
        bus(a, 8'h00, 1'b0, 1'b1);
    endtask
    task automatic idle(input int n);
        repeat (n) bus(3'h0, 8'h00, 1'b0, 1'b0);
    endtask
    // Count from zero for a while, stop, then read the low byte twice
    task automatic run_for(input logic [7:0] c, input int src, input int n,
                           input logic [7:0] e, input int t);
        wr(ADDR_COUNT_LOW, 8'h00);
        wr(ADDR_COUNT_HIGH, 8'h00);
        wr(ADDR_CONTROL, c);
        idle(1);
        if (src == 0)
            idle(n);
        else if (src == 1)
            far.pin_edges(n, 110);
        else
            far.xtal_cycles(n, 130);
        idle(4);
        wr(ADDR_CONTROL, c & 8'hfe);
        idle(2);
        rd(ADDR_COUNT_LOW, e, t);
        idle(1);
        rd(ADDR_COUNT_LOW, e, t);
    endtask
    initial
    begin
        #2000000;
        fails++;
        end_of_test();
    end
    initial
    begin
        void'($urandom(32'hd468b455));
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        rd(ADDR_CONTROL, CONTROL_RESET, 0);
        rd(ADDR_IRQ_STATUS, 8'h00, 0);
        wr(3'h7, 8'h5a);
        rd(3'h7, 8'h00, 0);
        v = $urandom;
        wr(ADDR_CONTROL, v[7:0]);
        rd(ADDR_CONTROL, v[7:0], 0);
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_COUNT_LOW, v[15:8]);
        wr(ADDR_COUNT_HIGH, v[23:16]);
        rd(ADDR_COUNT_LOW, v[15:8], 0);
        rd(ADDR_COUNT_HIGH, v[23:16], 0);
        wr(ADDR_CONTROL, 8'h02);
        wr(ADDR_COUNT_HIGH, 8'hab);
        rd(ADDR_COUNT_LOW, v[15:8], 0);
        rd(ADDR_COUNT_HIGH, v[23:16], 0);
        wr(ADDR_COUNT_HIGH, 8'hab);
        wr(ADDR_COUNT_LOW, 8'hcd);
        rd(ADDR_COUNT_LOW, 8'hcd, 0);
        rd(ADDR_COUNT_HIGH, 8'hab, 0);
        wr(ADDR_CONTROL, 8'h00);
        // Internal sources, bypass bit toggled to show it is ignored
        // Run bit stands for n + 6 edges: load, n idle, four idle, stop
        for (k = 0; k < 8; k++)
            run_for({1'b0, k[2], k[1:0], 1'b0, k[0], 2'b01}, 0, 64,
                    8'(70 / ((k[2] ? 1 : INSTR_DIV) << k[1:0])), 2);
        // External pin and crystal, synchronised and not
        for (k = 0; k < 4; k++)
        begin
            // Crystal runs in high-power, then in digital mode
            osc_cfg <= (k == 3) ? OSC_DIGITAL :
                       (k == 2) ? OSC_HIGH_POWER : OSC_LOW_POWER;
            run_for({2'b10, k[1:0], k[1], k[0], 2'b01}, 1 + k[1], 16,
                    8'(16 >> k[1:0]), 0);
        end
        wr(ADDR_IRQ_ENABLE, 8'h01);
        wr(ADDR_COUNT_LOW, 8'hfe);
        wr(ADDR_COUNT_HIGH, 8'hff);
        wr(ADDR_CONTROL, 8'h41);
        idle(1);
        k = 0;
        while (irq !== 1'b1 && k < 50)
        begin
            @(negedge sys_clk);
            k++;
        end
        cmp_bit(1'b1, irq);
        if (k == 50)
            end_of_test();
        wr(ADDR_CONTROL, 8'h00);
        rd(ADDR_IRQ_STATUS, 8'h01, 0);
        wr(ADDR_IRQ_ENABLE, 8'h00);
        idle(1);
        @(negedge sys_clk);
        cmp_bit(1'b0, irq);
        wr(ADDR_IRQ_ENABLE, 8'h01);
        idle(1);
        @(negedge sys_clk);
        cmp_bit(1'b1, irq);
        wr(ADDR_IRQ_CLEAR, 8'h01);
        rd(ADDR_IRQ_CLEAR, 8'h00, 0);
        idle(3);
        @(negedge sys_clk);
        cmp_bit(1'b0, irq);
        end_of_test();
    end
endmodule
